// File: ovren_pkg.sv
// Constants, types and helpers shared by the overrange enable register bank
//------------------------------------------------------------------------------
// How it works
// (RULE1) Bit 15 of a command word is the direction: zero asks to read the register, one asks to write it.
// (RULE2) Bits 14 to 9 carry the register select, 0x0A for the group A register and 0x0B for group B.
// (RULE3) Bit 8 of both enable registers is read-only and always reads as zero.
// (RULE4) Group A bits 7 to 4 add 20% to channels 7 to 4 on top of the range from range register 0x05.
// (RULE5) Group A bits 3 to 0 add 20% to channels 3 to 0 on top of the range from range register 0x04.
// (RULE6) Group B bits 7 to 4 add 20% to channels 7 to 4 on top of the range from range register 0x07.
// (RULE7) Group B bits 3 to 0 add 20% to channels 3 to 0 on top of the range from range register 0x06.
// (RULE8) A channel whose enable bit is zero uses exactly its programmed range with no extension.
// (RULE9) After reset group B reads 0x1600 and group A 0x1400, with every enable bit clear.
// (RULE10) A write changes only the eight enable bits of the addressed register; bit 8 stays zero.
//------------------------------------------------------------------------------
package ovren_pkg;
	localparam int          OVREN_CHANNELS      = 8;
	localparam int          OVREN_AW            = 8;
	localparam logic [5:0]  OVREN_IDX_GRP_A     = 6'h0A;
	localparam logic [5:0]  OVREN_IDX_GRP_B     = 6'h0B;
	localparam logic [5:0]  OVREN_IDX_STATUS    = 6'h0C;
	localparam logic [5:0]  OVREN_SEL_GRP_A     = 6'h0A;
	localparam logic [5:0]  OVREN_SEL_GRP_B     = 6'h0B;
	localparam logic        OVREN_DIR_READ      = 1'h0;
	localparam logic        OVREN_DIR_WRITE     = 1'h1;
	localparam logic [15:0] OVREN_GRP_A_RESET   = 16'h1400;
	localparam logic [15:0] OVREN_GRP_B_RESET   = 16'h1600;
	localparam logic [31:0] OVREN_UNMAPPED_DATA = 32'h0;
	localparam int          OVREN_STAT_MISS_BIT = 16;
	localparam int          OVREN_STAT_RDC_BIT  = 17;

	typedef struct packed {
		logic       dir;
		logic [5:0] sel;
		logic       rsvd;
		logic [7:0] en;
	} ovren_word_type;

	typedef struct packed {
		logic [1:0] range;
		logic       extend;
	} ovren_chan_type;

	function automatic logic [7:0] ovren_ext_bits(input ovren_chan_type [OVREN_CHANNELS-1:0] c);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < OVREN_CHANNELS; i++)
			b[i] = c[i].extend;
		return b;
	endfunction

	function automatic logic [15:0] ovren_rng_bits(input ovren_chan_type [OVREN_CHANNELS-1:0] c);
		logic [15:0] b;
		b = 16'h0000;
		for (int i = 0; i < OVREN_CHANNELS; i++)
			b[2*i +: 2] = c[i].range;
		return b;
	endfunction
endpackage

// File: ovren_group_reg.sv
// One channel-group enable register with its command decode
module ovren_group_reg
	import ovren_pkg::*;
#(
	parameter logic [15:0] RESET_WORD = OVREN_GRP_A_RESET
)(
	input  wire logic           clk_in,       // System clock
	input  wire logic           rst_n_in,     // Synchronised reset, active low
	input  wire logic           wr_stb_in,    // Accepted bus write to this slot
	input  ovren_word_type      cmd_in,       // Command word written
	output ovren_word_type      word_out,     // Read-back word
	output logic [7:0]          en_out,       // Channel enables, from register
	output logic                sel_miss_out  // Write with a foreign select
);
	localparam logic [5:0] SEL = RESET_WORD[14:9];

	logic [7:0] en_r;
	logic       hit_w;

	if (RESET_WORD[8] != 1'b0 || RESET_WORD[15] != 1'b0)
	begin : g_bad_reset
		$error("reset word must have bits 15 and 8 clear");
	end

	assign hit_w = wr_stb_in && (cmd_in.dir == OVREN_DIR_WRITE) && (cmd_in.sel == SEL); // see RULE1 see RULE2

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			en_r <= RESET_WORD[7:0]; // see RULE9
		else if (hit_w)
			en_r <= cmd_in.en; // see RULE10
	end

	assign en_out       = en_r;
	assign word_out     = '{dir: OVREN_DIR_READ, sel: SEL, rsvd: 1'b0, en: en_r}; // see RULE3
	assign sel_miss_out = wr_stb_in && (cmd_in.dir == OVREN_DIR_WRITE) && (cmd_in.sel != SEL);

	property p_only_hit_changes;
		@(posedge clk_in) disable iff (!rst_n_in) !hit_w |=> en_out == $past(en_out);
	endproperty
	a_only_hit_changes: assert property (p_only_hit_changes) else $error("enables moved without a write"); // see RULE10

	property p_rsvd_zero;
		@(posedge clk_in) disable iff (!rst_n_in) word_out.rsvd == 1'b0 && word_out.sel == SEL;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit or select wrong"); // see RULE3

	property p_reset_value;
		@(posedge clk_in) $rose(rst_n_in) |-> {word_out} == RESET_WORD;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("reset word wrong"); // see RULE9
endmodule // ovren_group_reg

// File: ovren_range_apply.sv
// Combines each channel's programmed range with its extension enable
module ovren_range_apply
	import ovren_pkg::*;
#(
	parameter int CHANNELS = OVREN_CHANNELS
)(
	input  wire logic                    clk_in,    // System clock
	input  wire logic                    rst_n_in,  // Synchronised reset, active low
	input  wire logic [2*CHANNELS-1:0]   range_in,  // Programmed range codes
	input  wire logic [CHANNELS-1:0]     en_in,     // Extension enables
	output ovren_chan_type [CHANNELS-1:0] cfg_out   // Effective setting per channel
);
	if (CHANNELS != OVREN_CHANNELS)
	begin : g_bad_channels
		$error("register holds exactly eight channel enables");
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cfg_out <= '0;
		else
			for (int i = 0; i < CHANNELS; i++)
			begin
				cfg_out[i].range  <= range_in[2*i +: 2]; // see RULE8
				cfg_out[i].extend <= en_in[i];
			end
	end

	for (genvar k = 0; k < CHANNELS; k++)
	begin : g_chk
		property p_plain_range;
			@(posedge clk_in) disable iff (!rst_n_in)
			!en_in[k] |=> !cfg_out[k].extend && cfg_out[k].range == $past(range_in[2*k +: 2]);
		endproperty
		a_plain_range: assert property (p_plain_range) else $error("disabled channel not plain"); // see RULE8
	end
endmodule // ovren_range_apply

// File: ovren_regs.sv
// Avalon-MM register bank holding the per-channel 20% range extension enables
//
// Decided for this implementation: the Avalon-MM interface to the registers.
module ovren_regs
	import ovren_pkg::*;
#(
	parameter int ADDR_W = OVREN_AW
)(
	input  wire logic                 sys_clk_in,          // 50 MHz system clock
	input  wire logic                 rst_n_in,            // Asynchronous reset, active low
	input  wire logic [ADDR_W-1:0]    avs_address_in,      // Byte address
	input  wire logic                 avs_read_in,         // Read request
	input  wire logic                 avs_write_in,        // Write request
	input  wire logic [31:0]          avs_writedata_in,    // Write data
	input  wire logic [3:0]           avs_byteenable_in,   // Byte lanes
	output logic [31:0]               avs_readdata_out,    // Read data, from register
	output logic                      avs_waitrequest_out, // Stall
	input  wire logic [7:0]           range_a_lo_in,       // Group A ch 3..0 range codes
	input  wire logic [7:0]           range_a_hi_in,       // Group A ch 7..4 range codes
	input  wire logic [7:0]           range_b_lo_in,       // Group B ch 3..0 range codes
	input  wire logic [7:0]           range_b_hi_in,       // Group B ch 7..4 range codes
	output ovren_chan_type [7:0]      chan_a_cfg_out,      // Group A effective settings
	output ovren_chan_type [7:0]      chan_b_cfg_out,      // Group B effective settings
	output logic [7:0]                extend_en_a_out,     // Group A enables, from register
	output logic [7:0]                extend_en_b_out      // Group B enables, from register
);
	if (ADDR_W < 8)
	begin : g_bad_addr
		$error("address must reach byte offset 0x30");
	end

	//--------------------------------------------------------------------------
	// Reset release
	//--------------------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n;

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	//--------------------------------------------------------------------------
	// Address decode
	//--------------------------------------------------------------------------
	logic [5:0]     idx_w;
	logic           aligned_w;
	logic           hit_a_w;
	logic           hit_b_w;
	logic           hit_s_w;
	logic           lanes_ok_w;
	ovren_word_type cmd_w;

	assign idx_w      = avs_address_in[7:2];
	assign aligned_w  = (avs_address_in[1:0] == 2'h0) && ((avs_address_in >> 8) == '0);
	assign hit_a_w    = aligned_w && (idx_w == OVREN_IDX_GRP_A);
	assign hit_b_w    = aligned_w && (idx_w == OVREN_IDX_GRP_B);
	assign hit_s_w    = aligned_w && (idx_w == OVREN_IDX_STATUS);
	assign lanes_ok_w = &avs_byteenable_in[1:0];
	assign cmd_w      = ovren_word_type'(avs_writedata_in[15:0]);

	//--------------------------------------------------------------------------
	// Handshake: one wait state on every access
	//--------------------------------------------------------------------------
	logic busy_w;
	logic ack_r;
	logic wr_go_w;
	logic rd_take_w;

	assign busy_w              = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = busy_w & ~ack_r;
	assign wr_go_w             = avs_write_in & ack_r & lanes_ok_w;
	assign rd_take_w           = avs_read_in & ~ack_r;

	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= busy_w & ~ack_r;
	end

	//--------------------------------------------------------------------------
	// Enable registers
	//--------------------------------------------------------------------------
	ovren_word_type word_a_w;
	ovren_word_type word_b_w;
	logic           miss_a_w;
	logic           miss_b_w;

	ovren_group_reg #(
		.RESET_WORD   (OVREN_GRP_A_RESET)
	) u_grp_a (
		.clk_in       (sys_clk_in),
		.rst_n_in     (rst_n),
		.wr_stb_in    (wr_go_w && hit_a_w),
		.cmd_in       (cmd_w),
		.word_out     (word_a_w),
		.en_out       (extend_en_a_out),
		.sel_miss_out (miss_a_w)
	);

	ovren_group_reg #(
		.RESET_WORD   (OVREN_GRP_B_RESET)
	) u_grp_b (
		.clk_in       (sys_clk_in),
		.rst_n_in     (rst_n),
		.wr_stb_in    (wr_go_w && hit_b_w),
		.cmd_in       (cmd_w),
		.word_out     (word_b_w),
		.en_out       (extend_en_b_out),
		.sel_miss_out (miss_b_w)
	);

	//--------------------------------------------------------------------------
	// Command tracking
	//--------------------------------------------------------------------------
	logic       grp_wr_w;
	logic       rd_cmd_w;
	logic       match_w;
	logic [5:0] ptr_r;
	logic       rdc_r;
	logic       miss_r;

	assign grp_wr_w = wr_go_w && (hit_a_w || hit_b_w);
	assign rd_cmd_w = grp_wr_w && (cmd_w.dir == OVREN_DIR_READ); // see RULE1
	assign match_w  = grp_wr_w && !rd_cmd_w && !miss_a_w && !miss_b_w;

	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			ptr_r <= 6'h00;
		else if (rd_cmd_w)
			ptr_r <= cmd_w.sel; // see RULE2
	end

	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			rdc_r <= 1'b0;
		else if (grp_wr_w)
			rdc_r <= rd_cmd_w;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			miss_r <= 1'b0;
		else if (miss_a_w || miss_b_w)
			miss_r <= 1'b1;
		else if (match_w)
			miss_r <= 1'b0;
	end

	//--------------------------------------------------------------------------
	// Read-back
	//--------------------------------------------------------------------------
	logic [15:0] ptr_word_w;
	logic [31:0] status_w;
	logic [31:0] rd_val_w;

	always_comb
	begin
		case (ptr_r)
			OVREN_SEL_GRP_A: ptr_word_w = word_a_w;
			OVREN_SEL_GRP_B: ptr_word_w = word_b_w;
			default:         ptr_word_w = 16'h0000;
		endcase
	end

	always_comb
	begin
		status_w                      = 32'h0;
		status_w[15:0]                = ptr_word_w;
		status_w[OVREN_STAT_MISS_BIT] = miss_r;
		status_w[OVREN_STAT_RDC_BIT]  = rdc_r;
	end

	always_comb
	begin
		if (hit_a_w)
			rd_val_w = {16'h0000, word_a_w}; // see RULE3
		else if (hit_b_w)
			rd_val_w = {16'h0000, word_b_w};
		else if (hit_s_w)
			rd_val_w = status_w;
		else
			rd_val_w = OVREN_UNMAPPED_DATA;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			avs_readdata_out <= 32'h0;
		else if (rd_take_w)
			avs_readdata_out <= rd_val_w;
	end

	//--------------------------------------------------------------------------
	// Range extension per channel
	//--------------------------------------------------------------------------
	ovren_range_apply #(
		.CHANNELS (OVREN_CHANNELS)
	) u_apply_a (
		.clk_in   (sys_clk_in),
		.rst_n_in (rst_n),
		.range_in ({range_a_hi_in, range_a_lo_in}), // see RULE4 see RULE5
		.en_in    (extend_en_a_out),
		.cfg_out  (chan_a_cfg_out)
	);

	ovren_range_apply #(
		.CHANNELS (OVREN_CHANNELS)
	) u_apply_b (
		.clk_in   (sys_clk_in),
		.rst_n_in (rst_n),
		.range_in ({range_b_hi_in, range_b_lo_in}), // see RULE6 see RULE7
		.en_in    (extend_en_b_out),
		.cfg_out  (chan_b_cfg_out)
	);

	//--------------------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------------------
	logic [7:0]  ext_a_w;
	logic [7:0]  ext_b_w;
	logic [15:0] rng_a_w;
	logic [15:0] rng_b_w;

	assign ext_a_w = ovren_ext_bits(chan_a_cfg_out);
	assign ext_b_w = ovren_ext_bits(chan_b_cfg_out);
	assign rng_a_w = ovren_rng_bits(chan_a_cfg_out);
	assign rng_b_w = ovren_rng_bits(chan_b_cfg_out);

	property p_read_dir_keeps;
		@(posedge sys_clk_in) disable iff (!rst_n)
		wr_go_w && hit_a_w && cmd_w.dir == OVREN_DIR_READ
		|=> extend_en_a_out == $past(extend_en_a_out) ##1 extend_en_a_out == $past(extend_en_a_out, 2);
	endproperty
	a_read_dir_keeps: assert property (p_read_dir_keeps) else $error("read command changed enables"); // see RULE1

	property p_foreign_sel;
		@(posedge sys_clk_in) disable iff (!rst_n)
		wr_go_w && hit_b_w && cmd_w.dir == OVREN_DIR_WRITE && cmd_w.sel != OVREN_SEL_GRP_B
		|=> $stable(extend_en_b_out) && miss_r;
	endproperty
	a_foreign_sel: assert property (p_foreign_sel) else $error("foreign select not refused"); // see RULE2

	property p_rsvd_read;
		@(posedge sys_clk_in) disable iff (!rst_n)
		rd_take_w && (hit_a_w || hit_b_w)
		|=> avs_readdata_out[8] == 1'b0 && avs_readdata_out[31:15] == 17'h0 && !avs_waitrequest_out;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read-back bits not zero"); // see RULE3

	property p_grp_a_hi;
		@(posedge sys_clk_in) disable iff (!rst_n)
		1'b1 |=> ext_a_w[7:4] == $past(extend_en_a_out[7:4]) && rng_a_w[15:8] == $past(range_a_hi_in);
	endproperty
	a_grp_a_hi: assert property (p_grp_a_hi) else $error("group A upper channels wrong"); // see RULE4

	property p_grp_a_lo;
		@(posedge sys_clk_in) disable iff (!rst_n)
		1'b1 |=> ext_a_w[3:0] == $past(extend_en_a_out[3:0]) && rng_a_w[7:0] == $past(range_a_lo_in);
	endproperty
	a_grp_a_lo: assert property (p_grp_a_lo) else $error("group A lower channels wrong"); // see RULE5

	property p_grp_b_hi;
		@(posedge sys_clk_in) disable iff (!rst_n)
		1'b1 |=> ext_b_w[7:4] == $past(extend_en_b_out[7:4]) && rng_b_w[15:8] == $past(range_b_hi_in);
	endproperty
	a_grp_b_hi: assert property (p_grp_b_hi) else $error("group B upper channels wrong"); // see RULE6

	property p_grp_b_lo;
		@(posedge sys_clk_in) disable iff (!rst_n)
		1'b1 |=> ext_b_w[3:0] == $past(extend_en_b_out[3:0]) && rng_b_w[7:0] == $past(range_b_lo_in);
	endproperty
	a_grp_b_lo: assert property (p_grp_b_lo) else $error("group B lower channels wrong"); // see RULE7

	property p_reset_clear;
		@(posedge sys_clk_in) $rose(rst_n) |-> extend_en_a_out == 8'h00 && extend_en_b_out == 8'h00;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("enables not clear after reset"); // see RULE9

	property p_write_lands;
		@(posedge sys_clk_in) disable iff (!rst_n)
		wr_go_w && hit_a_w && cmd_w.dir == OVREN_DIR_WRITE && cmd_w.sel == OVREN_SEL_GRP_A
		|=> extend_en_a_out == $past(cmd_w.en) && word_a_w.rsvd == 1'b0;
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write did not land"); // see RULE10

	property p_one_wait;
		@(posedge sys_clk_in) disable iff (!rst_n)
		busy_w && !ack_r |-> avs_waitrequest_out ##1 (!avs_waitrequest_out || !busy_w);
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");

	property p_lanes_refused;
		@(posedge sys_clk_in) disable iff (!rst_n)
		avs_write_in && ack_r && !lanes_ok_w |=> $stable(extend_en_a_out) && $stable(extend_en_b_out);
	endproperty
	a_lanes_refused: assert property (p_lanes_refused) else $error("partial lane write changed enables"); // see RULE10

	property p_rd_word_a;
		@(posedge sys_clk_in) disable iff (!rst_n)
		rd_take_w && hit_a_w
		|=> avs_readdata_out == {16'h0000, OVREN_DIR_READ, OVREN_SEL_GRP_A, 1'b0, $past(extend_en_a_out)};
	endproperty
	a_rd_word_a: assert property (p_rd_word_a) else $error("group A read-back word wrong"); // see RULE3

	property p_rd_word_b;
		@(posedge sys_clk_in) disable iff (!rst_n)
		rd_take_w && hit_b_w
		|=> avs_readdata_out == {16'h0000, OVREN_DIR_READ, OVREN_SEL_GRP_B, 1'b0, $past(extend_en_b_out)};
	endproperty
	a_rd_word_b: assert property (p_rd_word_b) else $error("group B read-back word wrong"); // see RULE2

	property p_unmapped_zero;
		@(posedge sys_clk_in) disable iff (!rst_n)
		rd_take_w && !hit_a_w && !hit_b_w && !hit_s_w |=> avs_readdata_out == OVREN_UNMAPPED_DATA;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // see RULE2

	property p_ptr_latch;
		@(posedge sys_clk_in) disable iff (!rst_n)
		rd_cmd_w |=> ptr_r == $past(cmd_w.sel) && rdc_r;
	endproperty
	a_ptr_latch: assert property (p_ptr_latch) else $error("read command select not latched"); // see RULE1

	property p_write_lands_b;
		@(posedge sys_clk_in) disable iff (!rst_n)
		wr_go_w && hit_b_w && cmd_w.dir == OVREN_DIR_WRITE && cmd_w.sel == OVREN_SEL_GRP_B
		|=> extend_en_b_out == $past(cmd_w.en) && word_b_w.rsvd == 1'b0;
	endproperty
	a_write_lands_b: assert property (p_write_lands_b) else $error("group B write did not land"); // see RULE10
endmodule // ovren_regs

// File: ovren_host_model.sv
// Host controller model issuing command words over Avalon-MM
module ovren_host_model
	import ovren_pkg::*;
(
	input  wire logic        clk_in,         // System clock
	input  wire logic        waitrequest_in, // Slave stall
	input  wire logic [31:0] readdata_in,    // Slave read data
	output logic [7:0]       address_out,    // Byte address
	output logic             read_out,       // Read request
	output logic             write_out,      // Write request
	output logic [31:0]      writedata_out,  // Write data
	output logic [3:0]       byteenable_out  // Byte lanes
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		address_out    = 8'h00;
		read_out       = 1'b0;
		write_out      = 1'b0;
		writedata_out  = 32'h00000000;
		byteenable_out = 4'hF;
	end

	// Command word: direction, select, reserved zero, enables
	function automatic logic [31:0] cmd(input logic dir, input logic [5:0] sel, input logic [7:0] en);
		return {16'h0000, dir, sel, 1'b0, en};
	endfunction

	// One bus cycle, held until waitrequest is seen low
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_in);
		address_out   <= a;
		writedata_out <= d;
		write_out     <= we;
		read_out      <= !we;
		do
		begin
			@(posedge clk_in);
		end
		while (waitrequest_in !== 1'b0);
		q = readdata_in;
		read_out      <= 1'b0;
		write_out     <= 1'b0;
		address_out   <= ~a;
		writedata_out <= ~d;
	endtask

	// Byte lanes for the following transfers
	task automatic set_lanes(input logic [3:0] b);
		@(posedge clk_in);
		byteenable_out <= b;
	endtask
endmodule // ovren_host_model

// File: tb_top.sv
// Self-checking bench for the overrange enable register bank
module tb_top
	import ovren_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 sys_clk;
	logic                 rst_n;
	logic [7:0]           addr;
	logic                 rd;
	logic                 wr;
	logic [31:0]          wdata;
	logic [3:0]           be;
	logic [31:0]          rdata;
	logic                 waitreq;
	logic [7:0]           a_lo, a_hi, b_lo, b_hi;
	ovren_chan_type [7:0] cfg_a, cfg_b;
	logic [7:0]           en_a, en_b;
	int                   failures, cmp_count, cycles;

	ovren_regs dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .avs_address_in(addr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(waitreq), .range_a_lo_in(a_lo), .range_a_hi_in(a_hi), .range_b_lo_in(b_lo),
		.range_b_hi_in(b_hi), .chan_a_cfg_out(cfg_a), .chan_b_cfg_out(cfg_b), .extend_en_a_out(en_a),
		.extend_en_b_out(en_b));

	ovren_host_model host (.clk_in(sys_clk), .waitrequest_in(waitreq), .readdata_in(rdata),
		.address_out(addr), .read_out(rd), .write_out(wr), .writedata_out(wdata), .byteenable_out(be));

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		if (failures == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic reset_dut;
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		host.xfer(1'b0, a, 32'h00000000, q);
		chk(q, exp);
	endtask

	task automatic wrw(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		host.xfer(1'b1, a, d, q);
		repeat (3) @(posedge sys_clk);
	endtask

	// Each channel: plain range code plus its extend bit
	task automatic cfg_chk(input ovren_chan_type [7:0] c, input logic [15:0] r, input logic [7:0] e);
		for (int i = 0; i < 8; i++)
			chk({29'h0, c[i]}, {29'h0, r[2*i +: 2], e[i]});
	endtask

	// Hang guard
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			failures++;
			final_report;
		end
	end

	initial
	begin
		logic [31:0] q;
		failures  = 0;
		cmp_count = 0;
		cycles    = 0;
		rst_n     = 1'b0;
		a_lo      = 8'h1B;
		a_hi      = 8'hE4;
		b_lo      = 8'h6C;
		b_hi      = 8'h93;
		reset_dut;
		chk(en_a, 32'h0);
		chk(en_b, 32'h0);
		rdchk(8'h28, 32'h00001400);
		rdchk(8'h2C, 32'h00001600);
		cfg_chk(cfg_a, {a_hi, a_lo}, 8'h00);
		cfg_chk(cfg_b, {b_hi, b_lo}, 8'h00);
		// Reserved bit set in the written word must not stick
		wrw(8'h28, host.cmd(1'b1, 6'h0A, 8'h5A) | 32'h00000100);
		rdchk(8'h28, 32'h0000145A);
		chk(en_a, 32'h5A);
		chk(en_b, 32'h00);
		cfg_chk(cfg_a, {a_hi, a_lo}, 8'h5A);
		wrw(8'h2C, host.cmd(1'b1, 6'h0B, 8'hA5) | 32'h00000100);
		rdchk(8'h2C, 32'h000016A5);
		cfg_chk(cfg_b, {b_hi, b_lo}, 8'hA5);
		// Walk one enable across every channel of both groups
		for (int i = 0; i < 8; i++)
		begin
			wrw(8'h28, host.cmd(1'b1, 6'h0A, 8'h01 << i));
			wrw(8'h2C, host.cmd(1'b1, 6'h0B, 8'h80 >> i));
			cfg_chk(cfg_a, {a_hi, a_lo}, 8'h01 << i);
			cfg_chk(cfg_b, {b_hi, b_lo}, 8'h80 >> i);
		end
		// Foreign select and read direction leave enables alone
		wrw(8'h28, host.cmd(1'b1, 6'h0B, 8'hFF));
		chk(en_a, 32'h80);
		wrw(8'h2C, host.cmd(1'b1, 6'h0A, 8'hFF));
		chk(en_b, 32'h01);
		wrw(8'h28, host.cmd(1'b0, 6'h0A, 8'hFF));
		chk(en_a, 32'h80);
		rdchk(8'h28, 32'h00001480);
		rdchk(8'h30, 32'h00031480);
		// Range inputs change under a live enable
		a_lo <= 8'hC6;
		a_hi <= 8'h39;
		repeat (3) @(posedge sys_clk);
		cfg_chk(cfg_a, {8'h39, 8'hC6}, 8'h80);
		// Back to back write then read
		host.xfer(1'b1, 8'h2C, host.cmd(1'b1, 6'h0B, 8'h3C), q);
		rdchk(8'h2C, 32'h0000163C);
		rdchk(8'h30, 32'h00001480);
		rdchk(8'h3C, 32'h00000000);
		rdchk(8'h29, 32'h00000000);
		// Write with the low lanes off is ignored
		host.set_lanes(4'hC);
		wrw(8'h2C, host.cmd(1'b1, 6'h0B, 8'hFF));
		host.set_lanes(4'hF);
		chk(en_b, 32'h3C);
		// Reset in mid-run restores defaults
		reset_dut;
		chk(en_b, 32'h0);
		rdchk(8'h2C, 32'h00001600);
		rdchk(8'h28, 32'h00001400);
		final_report;
	end
endmodule // tb_top
